// ---- verilog/sfs_pkg.sv ----
//==============================================================================
`default_nettype none
package sfs_pkg;
  // format codes
  localparam logic [1:0] FMT_DIRECT   = 2'h0;
  localparam logic [1:0] FMT_MASTER   = 2'h1;
  localparam logic [1:0] FMT_FOLLOWER = 2'h2;
  localparam logic [1:0] FMT_OFFSET   = 2'h3;
  localparam int         DW           = 16;
  // register offsets (byte addresses)
  localparam logic [7:0] A_FMT        = 8'h00; // [1:0] primary, [3:2] secondary
  localparam logic [7:0] A_DIRECT     = 8'h04;
  localparam logic [7:0] A_P_PLUS     = 8'h08;
  localparam logic [7:0] A_P_MINUS    = 8'h0c;
  localparam logic [7:0] A_S_PLUS     = 8'h10;
  localparam logic [7:0] A_S_MINUS    = 8'h14;
  localparam logic [7:0] A_P_AUXRPM   = 8'h18;
  localparam logic [7:0] A_S_AUXRPM   = 8'h1c;
  localparam logic [7:0] A_AUXPPR     = 8'h20;
  localparam logic [7:0] A_P_SCALE    = 8'h24; // follower and offset multiplier, q8
  localparam logic [7:0] A_S_SCALE    = 8'h28;
  localparam logic [7:0] A_STATUS     = 8'h2c;
  localparam logic [7:0] A_SPEED      = 8'h30;
  // field positions
  localparam int P_FMT_LSB = 0;
  localparam int S_FMT_LSB = 2;
  // reset values
  localparam logic [DW-1:0] RST_AUXRPM = 16'h03e8;
  localparam logic [DW-1:0] RST_AUXPPR = 16'h003c;
  localparam logic [DW-1:0] RST_SCALE  = 16'h0100;
  localparam logic [DW-1:0] RST_ZERO   = 16'h0000;
  localparam logic [3:0]    RST_FMT    = 4'h9;     // primary master, secondary follower
  // full-scale aux frequency that yields unity aux gain
  localparam int AUX_FS_REF = 10000;
  typedef enum logic [1:0] {SFS_IDLE, SFS_DIV, SFS_DONE} sfs_div_st_t;
endpackage
`default_nettype wire

// ---- verilog/sfs_bias_pair.sv ----
`timescale 1ns/100ps
`default_nettype none
// one exclusive plus/minus bias pair
module sfs_bias_pair
  import sfs_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wr_plus_i,
  input  wire logic         wr_minus_i,
  input  wire logic [W-1:0] data_i,
  output logic      [W-1:0] plus_o,
  output logic      [W-1:0] minus_o
);
  //============================================================================
  // storage
  // a nonzero entry clears the partner so only one side is ever live
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      plus_o  <= '0;
      minus_o <= '0;
    end
    else if (wr_plus_i)
    begin
      plus_o <= data_i;
      if (data_i != '0) minus_o <= '0;
    end
    else if (wr_minus_i)
    begin
      minus_o <= data_i;
      if (data_i != '0) plus_o <= '0;
    end
  end

  exclusive_a : assert property (@(posedge clk_i) disable iff (rst_i)
    (plus_o == '0) || (minus_o == '0))
    else $error("both biases nonzero");
endmodule
`default_nettype wire

// ---- verilog/sfs_div.sv ----
`timescale 1ns/100ps
`default_nettype none
// sequential unsigned divider, one quotient bit per cycle
module sfs_div
  import sfs_pkg::*;
#(
  parameter int W = 32
)(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] num_i,
  input  wire logic [W-1:0] den_i,
  output logic      [W-1:0] quot_o,
  output logic              done_o
);
  sfs_div_st_t      st;
  logic [W-1:0]     q;
  logic [W:0]       r;
  logic [W-1:0]     d;
  logic [5:0]       n;
  logic [W:0]       trial;

  assign trial = {r[W-1:0], q[W-1]};

  //============================================================================
  // restoring division; zero divisor gives zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st     <= SFS_IDLE;
      q      <= '0;
      r      <= '0;
      d      <= '0;
      n      <= '0;
      quot_o <= '0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      case (st)
        SFS_IDLE:
          if (start_i)
          begin
            q  <= num_i;
            r  <= '0;
            d  <= den_i;
            n  <= 6'(W);
            st <= SFS_DIV;
          end
        SFS_DIV:
        begin
          if (trial >= {1'b0, d})
          begin
            r <= trial - {1'b0, d};
            q <= {q[W-2:0], 1'b1};
          end
          else
          begin
            r <= trial;
            q <= {q[W-2:0], 1'b0};
          end
          n <= n - 6'h01;
          if (n == 6'h01) st <= SFS_DONE;
        end
        SFS_DONE:
        begin
          quot_o <= (d == '0) ? '0 : q;
          done_o <= 1'b1;
          st     <= SFS_IDLE;
        end
        default: st <= SFS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verilog/sfs_core.sv ----
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
// speed format selection core with wishbone parameter registers
module sfs_core
  import sfs_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // wishbone classic slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [7:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  output logic                      ack_o,
  // process inputs
  input  wire logic                 secondary_sel_i,
  input  wire logic                 run_i,
  input  wire logic [sfs_pkg::DW-1:0] ramped_speed_i,
  input  wire logic [sfs_pkg::DW-1:0] extref_speed_i,
  input  wire logic [sfs_pkg::DW-1:0] aux_freq_i,
  // drive outputs
  output logic      [sfs_pkg::DW-1:0] speed_cmd_o,
  output logic      [7:0]           direct_pct_o,
  output logic                      direct_mode_o,
  output logic                      ramp_bypass_o,
  output logic                      fb_bypass_o,
  output logic                      ilimit_bypass_o,
  output logic      [1:0]           active_fmt_o
);
  //============================================================================
  // parameter registers
  logic [1:0]    primary_format_code;
  logic [1:0]    secondary_format_code;
  logic [7:0]    direct_output_percent;
  logic [DW-1:0] p_aux_rpm_max;
  logic [DW-1:0] secondary_aux_rpm_max;
  logic [DW-1:0] aux_pulses_per_rev;
  logic [DW-1:0] p_scale;
  logic [DW-1:0] s_scale;
  logic [DW-1:0] primary_plus_bias;
  logic [DW-1:0] primary_minus_bias;
  logic [DW-1:0] secondary_plus_bias;
  logic [DW-1:0] secondary_minus_bias;

  logic          wr;
  logic          rd_hit;
  logic [31:0]   next_dat;

  // a write lands on the edge where the master sees ack, never while the request may still be withdrawn
  assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0] && sel_i[1];

  // whole-halfword writes only; partial lanes would break the pair exclusion
  // the percentage clips at full output so a stray large entry cannot overdrive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      primary_format_code   <= RST_FMT[1:0];
      secondary_format_code <= RST_FMT[3:2];
      direct_output_percent <= 8'h00;
      p_aux_rpm_max         <= RST_AUXRPM;
      secondary_aux_rpm_max <= RST_AUXRPM;
      aux_pulses_per_rev    <= RST_AUXPPR;
      p_scale               <= RST_SCALE;
      s_scale               <= RST_SCALE;
    end
    else if (wr)
    begin
      case (adr_i)
        A_FMT:
        begin
          primary_format_code   <= dat_i[P_FMT_LSB +: 2];
          secondary_format_code <= dat_i[S_FMT_LSB +: 2];
        end
        A_DIRECT:   direct_output_percent <= (dat_i[7:0] > 8'h64) ? 8'h64 : dat_i[7:0];
        A_P_AUXRPM: p_aux_rpm_max         <= dat_i[DW-1:0];
        A_S_AUXRPM: secondary_aux_rpm_max <= dat_i[DW-1:0];
        A_AUXPPR:   aux_pulses_per_rev    <= dat_i[DW-1:0];
        A_P_SCALE:  p_scale               <= dat_i[DW-1:0];
        A_S_SCALE:  s_scale               <= dat_i[DW-1:0];
        default: ;
      endcase
    end
  end

  // bias pairs, one per group
  sfs_bias_pair #(.W(DW)) u_pri_bias (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_plus_i  (wr && adr_i == A_P_PLUS),
    .wr_minus_i (wr && adr_i == A_P_MINUS),
    .data_i     (dat_i[DW-1:0]),
    .plus_o     (primary_plus_bias),
    .minus_o    (primary_minus_bias)
  );

  sfs_bias_pair #(.W(DW)) u_sec_bias (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_plus_i  (wr && adr_i == A_S_PLUS),
    .wr_minus_i (wr && adr_i == A_S_MINUS),
    .data_i     (dat_i[DW-1:0]),
    .plus_o     (secondary_plus_bias),
    .minus_o    (secondary_minus_bias)
  );

  //============================================================================
  // group selection
  logic [1:0]    fmt;
  logic [DW-1:0] g_scale;
  logic [DW-1:0] g_aux_rpm;
  logic [DW-1:0] g_plus;
  logic [DW-1:0] g_minus;

  // every constant except aux_pulses_per_rev and direct_output_percent follows the selected group
  // switching groups mid-run changes the command on the next edge, unramped
  always_comb
  begin
    fmt       = secondary_sel_i ? secondary_format_code : primary_format_code;
    g_scale   = secondary_sel_i ? s_scale : p_scale;
    g_aux_rpm = secondary_sel_i ? secondary_aux_rpm_max : p_aux_rpm_max;
    g_plus    = secondary_sel_i ? secondary_plus_bias : primary_plus_bias;
    g_minus   = secondary_sel_i ? secondary_minus_bias : primary_minus_bias;
  end

  //============================================================================
  // aux gain: full scale rpm*ppr/60 Hz; gain q8 = 10000*256/full scale
  logic [31:0] aux_fs;
  logic [31:0] gain_q8;
  logic        div_done;
  logic        div_busy;

  assign aux_fs = 32'(g_aux_rpm * aux_pulses_per_rev) / 32'd60;

  // recompute continuously; a new full scale or a group switch can take two divides
  // to appear, since a divide already under way still finishes with the old operands
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_busy <= 1'b0;
    else if (div_done)
      div_busy <= 1'b0;
    else if (!div_busy)
      div_busy <= 1'b1;
  end

  sfs_div #(.W(32)) u_gain_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (!div_busy),
    .num_i   (32'(AUX_FS_REF) << 8),
    .den_i   (aux_fs),
    .quot_o  (gain_q8),
    .done_o  (div_done)
  );

  //============================================================================
  // speed computation
  logic [31:0] follow_q8;
  logic [31:0] aux_term;
  logic signed [33:0] sum;
  logic [DW-1:0] next_speed;
  logic [DW-1:0] offset_speed;
  logic [DW-1:0] follow_speed;

  always_comb
  begin
    follow_q8 = 32'(extref_speed_i * g_scale);
    if (follow_q8[31:24] != 8'h00)
      follow_speed = 16'hffff;                                      // saturate, a wrap would drop the speed
    else
      follow_speed = follow_q8[23:8];
    aux_term  = 32'(aux_freq_i * gain_q8[DW-1:0]);
    sum       = 34'(follow_q8 >> 8) + 34'(aux_term >> 8)
              + 34'(g_plus) - 34'(g_minus);
    if (sum < 0)
      offset_speed = '0;
    else if (sum > 34'(16'hffff))
      offset_speed = 16'hffff;
    else
      offset_speed = sum[DW-1:0];
    case (fmt)
      FMT_MASTER:   next_speed = ramped_speed_i;
      FMT_FOLLOWER: next_speed = follow_speed;
      FMT_OFFSET:   next_speed = offset_speed;
      default:      next_speed = '0;                                // direct uses the percentage path
    endcase
  end

  // direct format jumps straight to the setpoint; run gates speed_cmd_o and direct_pct_o, not the mode or bypass flags
  // all drive outputs are registered so the stage sees them free of glitches
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      speed_cmd_o     <= '0;
      direct_pct_o    <= 8'h00;
      direct_mode_o   <= 1'b0;
      ramp_bypass_o   <= 1'b0;
      fb_bypass_o     <= 1'b0;
      ilimit_bypass_o <= 1'b0;
      active_fmt_o    <= FMT_DIRECT;
    end
    else
    begin
      active_fmt_o    <= fmt;
      direct_mode_o   <= (fmt == FMT_DIRECT);
      ramp_bypass_o   <= (fmt == FMT_DIRECT);
      fb_bypass_o     <= (fmt == FMT_DIRECT);
      ilimit_bypass_o <= (fmt == FMT_DIRECT);
      direct_pct_o    <= (run_i && fmt == FMT_DIRECT) ? direct_output_percent : 8'h00;
      speed_cmd_o     <= run_i ? next_speed : '0;
    end
  end

  //============================================================================
  // read mux and ack
  // status packs the bypass flag, the selection input, run and the active format
  always_comb
  begin
    rd_hit   = 1'b1;
    next_dat = 32'h0;
    case (adr_i)
      A_FMT:      next_dat = {28'h0, secondary_format_code, primary_format_code};
      A_DIRECT:   next_dat = {24'h0, direct_output_percent};
      A_P_PLUS:   next_dat = {16'h0, primary_plus_bias};
      A_P_MINUS:  next_dat = {16'h0, primary_minus_bias};
      A_S_PLUS:   next_dat = {16'h0, secondary_plus_bias};
      A_S_MINUS:  next_dat = {16'h0, secondary_minus_bias};
      A_P_AUXRPM: next_dat = {16'h0, p_aux_rpm_max};
      A_S_AUXRPM: next_dat = {16'h0, secondary_aux_rpm_max};
      A_AUXPPR:   next_dat = {16'h0, aux_pulses_per_rev};
      A_P_SCALE:  next_dat = {16'h0, p_scale};
      A_S_SCALE:  next_dat = {16'h0, s_scale};
      A_STATUS:   next_dat = {24'h0, 3'h0, ilimit_bypass_o, secondary_sel_i, run_i, active_fmt_o};
      A_SPEED:    next_dat = {16'h0, speed_cmd_o};
      default:    rd_hit   = 1'b0;
    endcase
  end

  // one wait state; unmapped reads return zero but still ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end
    else
    begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= rd_hit ? next_dat : 32'h0;
    end
  end

  //============================================================================
  // checks
  // format and drive gating
  direct_run_a : assert property (@(posedge clk_i) disable iff (rst_i)
    !run_i |=> direct_pct_o == 8'h00 && speed_cmd_o == '0)
    else $error("drive active while stopped");

  direct_pct_a : assert property (@(posedge clk_i) disable iff (rst_i)
    run_i && fmt == FMT_DIRECT |=> direct_pct_o == $past(direct_output_percent))
    else $error("direct output not applied at once");

  pct_limit_a : assert property (@(posedge clk_i) disable iff (rst_i)
    direct_pct_o <= 8'h64)
    else $error("direct output above full scale");

  pct_off_a : assert property (@(posedge clk_i) disable iff (rst_i)
    fmt != FMT_DIRECT |=> direct_pct_o == 8'h00)
    else $error("direct output outside direct format");

  bypass_flags_a : assert property (@(posedge clk_i) disable iff (rst_i)
    fmt == FMT_DIRECT |=> ramp_bypass_o && fb_bypass_o && ilimit_bypass_o)
    else $error("direct bypass flags missing");

  bypass_clear_a : assert property (@(posedge clk_i) disable iff (rst_i)
    fmt != FMT_DIRECT |=> !ramp_bypass_o && !fb_bypass_o && !direct_mode_o)
    else $error("ramp or feedback bypassed outside direct");

  ilimit_bypass_a : assert property (@(posedge clk_i) disable iff (rst_i)
    fmt != FMT_DIRECT |=> !ilimit_bypass_o)
    else $error("current limit bypassed outside direct");

  direct_speed_a : assert property (@(posedge clk_i) disable iff (rst_i)
    fmt == FMT_DIRECT |=> speed_cmd_o == '0)
    else $error("speed command used in direct");

  group_sel_a : assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> active_fmt_o == ($past(secondary_sel_i) ? $past(secondary_format_code)
                                                        : $past(primary_format_code)))
    else $error("wrong group format");

  fmt_write_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == A_FMT |=> primary_format_code == $past(dat_i[1:0]))
    else $error("format code not stored");

  fmt_sec_write_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == A_FMT |=> secondary_format_code == $past(dat_i[3:2]))
    else $error("secondary format code not stored");

  // speed paths
  master_pass_a : assert property (@(posedge clk_i) disable iff (rst_i)
    run_i && fmt == FMT_MASTER |=> speed_cmd_o == $past(ramped_speed_i))
    else $error("master speed not passed");

  follow_pri_a : assert property (@(posedge clk_i) disable iff (rst_i)
    run_i && fmt == FMT_FOLLOWER && !secondary_sel_i && 32'(extref_speed_i * p_scale) < 32'h0100_0000
    |=> speed_cmd_o == 16'(32'($past(extref_speed_i) * $past(p_scale)) >> 8))
    else $error("primary scale not applied");

  follow_sec_a : assert property (@(posedge clk_i) disable iff (rst_i)
    run_i && fmt == FMT_FOLLOWER && secondary_sel_i && 32'(extref_speed_i * s_scale) < 32'h0100_0000
    |=> speed_cmd_o == 16'(32'($past(extref_speed_i) * $past(s_scale)) >> 8))
    else $error("secondary scale not applied");

  offset_clamp_a : assert property (@(posedge clk_i) disable iff (rst_i)
    run_i && fmt == FMT_OFFSET && sum < 0 |=> speed_cmd_o == '0)
    else $error("negative offset not clamped");

  offset_sum_a : assert property (@(posedge clk_i) disable iff (rst_i)
    run_i && fmt == FMT_OFFSET && sum >= 0 && sum < 34'(16'hffff)
    |=> speed_cmd_o == $past(sum[DW-1:0]))
    else $error("offset sum wrong");

  // bus handshake
  ack_pulse_a : assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  ack_delay_a : assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack not given in the next cycle");

  rd_unmapped_a : assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !we_i && !ack_o && !rd_hit |=> dat_o == 32'h0)
    else $error("unmapped read returned data");
endmodule
`default_nettype wire

// ---- tb/sfs_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
// far side: drive stage state, frequency sensors and group selection switch
module sfs_partner (
  input  wire logic        clk_i,
  output logic             run_o,
  output logic             sel_o,
  output logic      [15:0] ramp_o,
  output logic      [15:0] ext_o,
  output logic      [15:0] aux_o
);
  // quiet stopped state at time zero
  initial
  begin
    run_o  = 1'b0;
    sel_o  = 1'b0;
    ramp_o = 16'h0000;
    ext_o  = 16'h0000;
    aux_o  = 16'h0000;
  end

  // sensors update just after an edge, like a synchronised counter would
  task automatic drive(input logic r, input logic s, input logic [15:0] rp, input logic [15:0] ex,
                       input logic [15:0] ax);
    @(posedge clk_i);
    run_o  <= r;
    sel_o  <= s;
    ramp_o <= rp;
    ext_o  <= ex;
    aux_o  <= ax;
  endtask
endmodule
`default_nettype wire

// ---- tb/speed_format_select_offset_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module speed_format_select_offset_tb_top;
  import sfs_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o, q;
  logic        ack_o, run, ssel, dmode, rbyp, fbyp, ibyp;
  logic [15:0] ramp, ext, aux, spd;
  logic [7:0]  pct;
  logic [1:0]  afmt;
  int          mismatches = 0;
  int          checks = 0;
  int          scl[2], gn[2], bias[2];
  int          pcts[4] = '{0, 10, 100, 150};

  // ==========================================================================
  // clock, instances
  always #5 clk_i = ~clk_i;
  sfs_partner part (.clk_i(clk_i), .run_o(run), .sel_o(ssel), .ramp_o(ramp), .ext_o(ext), .aux_o(aux));
  sfs_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .secondary_sel_i(ssel), .run_i(run),
    .ramped_speed_i(ramp), .extref_speed_i(ext), .aux_freq_i(aux), .speed_cmd_o(spd),
    .direct_pct_o(pct), .direct_mode_o(dmode), .ramp_bypass_o(rbyp), .fb_bypass_o(fbyp),
    .ilimit_bypass_o(ibyp), .active_fmt_o(afmt));

  // ==========================================================================
  // bench tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; waits for ack as long as it takes, the watchdog bounds it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do
    begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // integer model of the speed command for one format
  function automatic int model(int f, int r, int rp, int ex, int s, int ax, int g, int b);
    int v;
    v = (f == 1) ? rp : (f == 2) ? ex * s / 256 : (f == 3) ? ex * s / 256 + ax * g / 256 + b : 0;
    if (v < 0)
      v = 0;
    if (v > 65535)
      v = 65535;
    return r ? v : 0;
  endfunction

  // ==========================================================================
  // watchdog: the whole sequence needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    wrap_up();
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    void'($urandom(32'hedfcd497));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, A_FMT, 32'h0);
    chk(q, {28'h0, RST_FMT});
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    // direct format on the primary group, percent boundary at 100
    wb(1'b1, A_FMT, 32'h8);
    part.drive(1'b1, 1'b0, 16'($urandom), 16'($urandom), 16'($urandom));
    foreach (pcts[i])
    begin
      wb(1'b1, A_DIRECT, pcts[i]);
      repeat (3) @(posedge clk_i);
      chk(pct, (pcts[i] > 100) ? 100 : pcts[i]);
      chk({dmode, rbyp, fbyp, ibyp, spd}, {4'hf, 16'h0});
    end
    wb(1'b0, A_STATUS, 32'h0);
    chk(q, 32'h14);
    part.drive(1'b0, 1'b0, 16'h1234, 16'h0, 16'h0);
    repeat (3) @(posedge clk_i);
    chk(pct, 8'h00);
    // per-group constants; secondary full scale 5000 Hz doubles the aux gain
    scl = '{384, 512};
    gn = '{256, 512};
    bias = '{5, -7};
    wb(1'b1, A_P_SCALE, 32'h180);
    wb(1'b1, A_S_SCALE, 32'h200);
    wb(1'b1, A_P_AUXRPM, 32'd1000);
    wb(1'b1, A_S_AUXRPM, 32'd500);
    wb(1'b1, A_AUXPPR, 32'd600);
    wb(1'b1, A_P_PLUS, 32'd5);
    wb(1'b1, A_S_MINUS, 32'd7);
    for (int g = 0; g < 2; g++)
      for (int f = 0; f < 4; f++)
      begin
        wb(1'b1, A_FMT, (g != 0) ? {f[1:0], 2'(3 - f)} : {2'(3 - f), f[1:0]});
        part.drive(1'b1, g[0], 16'($urandom), 16'($urandom_range(1999)), 16'($urandom_range(999)));
        repeat (40) @(posedge clk_i);
        chk(afmt, f);
        chk(dmode, f == 0);
        chk({rbyp, fbyp, ibyp}, (f == 0) ? 3'h7 : 3'h0);
        chk(pct, (f == 0) ? 100 : 0);
        chk(spd, model(f, 1, ramp, ext, scl[g], aux, gn[g], bias[g]));
      end
    // exclusive pairs in both groups
    wb(1'b1, A_P_PLUS, 32'd9);
    wb(1'b1, A_P_MINUS, 32'hffff);
    wb(1'b0, A_P_PLUS, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, A_S_MINUS, 32'h0);
    chk(q, 32'd7);
    wb(1'b1, A_S_PLUS, 32'd3);
    wb(1'b0, A_S_MINUS, 32'h0);
    chk(q, 32'h0);
    // large negative bias on the primary group must not go below zero
    wb(1'b1, A_FMT, 32'h3);
    part.drive(1'b1, 1'b0, 16'h0, 16'd100, 16'd10);
    repeat (40) @(posedge clk_i);
    chk(spd, model(3, 1, 0, 100, 384, 10, 256, -65535));
    wb(1'b0, A_SPEED, 32'h0);
    chk(q, model(3, 1, 0, 100, 384, 10, 256, -65535));
    wrap_up();
  end
endmodule
`default_nettype wire
